// file: cfg_mem.sv
// configuration byte store with one write port, one read port and setting taps
`timescale 1ns/100ps
module cfg_mem #(
	parameter int DEPTH = wsc_pkg::CFG_DEPTH
) (
	// clock and reset
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// write port
	input  wire logic                      we,
	input  wire logic [wsc_pkg::CFG_AW-1:0] waddr,
	input  wire logic [7:0]                wdata,
	// read port
	input  wire logic [wsc_pkg::CFG_AW-1:0] raddr,
	output logic      [7:0]                rdata,
	// stored settings
	output logic      [7:0]                mode_byte,
	output logic      [15:0]               tp_word,
	output logic      [15:0]               tb_word,
	output logic      [15:0]               tw_word
);
	import wsc_pkg::*;

	if (DEPTH != CFG_DEPTH) begin : g_chk
		$error("cfg_mem depth must match the address width");
	end

	logic [7:0] mem_r [DEPTH];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= cfg_default(i);
			end
		end else if (we) begin
			mem_r[waddr] <= wdata;
		end
	end

	assign rdata     = mem_r[raddr];
	assign mode_byte = mem_r[ADDR_MODE];
	assign tp_word   = {mem_r[ADDR_TP], mem_r[ADDR_TP + 7'h01]};
	assign tb_word   = {mem_r[ADDR_TB], mem_r[ADDR_TB + 7'h01]};
	assign tw_word   = {mem_r[ADDR_TW], mem_r[ADDR_TW + 7'h01]};
endmodule

// file: pin_watch.sv
// level change detector for the reported pins
`timescale 1ns/100ps
module pin_watch #(
	parameter int W = 3
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// watched levels
	input  wire logic [W-1:0] level,
	input  wire logic [W-1:0] enable,
	output logic      [W-1:0] change
);
	if (W < 1) begin : g_chk
		$error("pin_watch needs at least one pin");
	end

	logic [W-1:0] prev_r;
	logic [W-1:0] en_d_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= '0;
			en_d_r <= '0;
		end else begin
			prev_r <= level;
			en_d_r <= enable;
		end
	end

	// a freshly enabled pin reports nothing until its level really moves
	assign change = enable & en_d_r & (level ^ prev_r);
endmodule

// file: tb_wiegand_cmd.sv
// self-checking bench of the serial command handler
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
	$display("unexpected at %0t: got %0h want %0h", $time, a, e); end end
module tb_wiegand_cmd;
	import wsc_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, rx_valid, tx_valid, tx_ready, wg_start, tamper_oe;
	logic [7:0]  rx_data, tx_data, wg_count, wg_rx_count = 8'h1a, e[$];
	logic [95:0] wg_bits, wg_rx_bits = {32'hf2627040, 64'h0};
	logic [15:0] wg_pulse_width, wg_bit_period;
	logic        tamper_out, ack_led, restart_req, slow = 1'b0, tamper_in = 1'b0, wg_pulse = 1'b0;
	logic [1:0]  gpio_in = 2'b00, gpio_out, gpio_oe;
	int          fails = 0, n_checks = 0, n;
	wiegand_cmd #(.RESET_CYCLES(20)) i_wiegand_cmd (.pclk, .presetn, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .rx_data, .rx_valid, .tx_data, .tx_valid,
		.tx_ready, .wg_bits, .wg_count, .wg_start, .wg_pulse_width, .wg_bit_period,
		.wg_pulse, .wg_rx_bits, .wg_rx_count, .tamper_in, .tamper_out,
		.tamper_oe, .gpio_in, .gpio_out, .gpio_oe, .ack_led, .restart_req);
	wsc_host i_wsc_host (.pclk, .slow, .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready);
	always #20 pclk = ~pclk;
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic t_regs();
		apb(REG_CTRL, 1'b0, 32'h0);
		`CHK(rd[0], 1'b1)
		apb(REG_STATUS, 1'b0, 32'h0);
		`CHK({rd[15:8], rd[1:0]}, {MODE_AUTO, 2'b10})
		apb(12'h00c, 1'b1, 32'h1);
		`CHK({er, rd}, {1'b1, 32'h0})
	endtask
	task automatic t_frame();
		i_wsc_host.send('{8'h55, 8'h55, 8'h01, 8'h1a, 8'hf2, 8'h62, 8'h70, 8'h40, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'haa, 8'h0d});
		for (n = 0; n < 8 && wg_start !== 1'b1; n++) @(posedge pclk);
		`CHK(wg_start, 1'b1)
		`CHK({wg_count, wg_bits}, {8'h1a, 32'hf2627040, 64'h0})
		`CHK({wg_pulse_width, wg_bit_period}, {DEF_TP, DEF_TB})
	endtask
	task automatic t_pins();
		i_wsc_host.send('{8'h55, 8'h55, 8'h02, 8'hff, 8'h3c, 8'h0d});
		i_wsc_host.send('{8'h55, 8'h55, 8'h03, 8'hff, 8'h00, 8'h0d});
		`CHK({tamper_oe, tamper_out, gpio_oe, gpio_out}, 6'b110000)
		slow <= 1'b1;
		gpio_in <= 2'b01;
		for (n = 0; n < 60 && i_wsc_host.got.size() < 6; n++) @(posedge pclk);
		e = '{8'h55, 8'h55, 8'h03, 8'hff, 8'h00, 8'h0d};
		foreach (e[i]) `CHK(i_wsc_host.got[i], e[i])
		slow <= 1'b0;
	endtask
	task automatic t_err();
		i_wsc_host.send('{8'h55, 8'h54, 8'h02, 8'h00, 8'h00, 8'h0d});
		apb(REG_ERR, 1'b0, 32'h0);
		`CHK(rd[2:0], ERR_SYNC)
		i_wsc_host.send('{8'h55, 8'h55, 8'h02, 8'h00, 8'h00, 8'h0c});
		apb(REG_ERR, 1'b0, 32'h0);
		`CHK({tamper_out, rd[2:0]}, {1'b1, ERR_TERM})
		apb(REG_ERR, 1'b1, 32'h0);
		apb(REG_ERR, 1'b0, 32'h0);
		`CHK(rd[2:0], ERR_NONE)
		i_wsc_host.send('{8'h55, 8'h55, 8'h07});
		apb(REG_ERR, 1'b0, 32'h0);
		`CHK(rd[2:0], ERR_UNKNOWN)
	endtask
	task automatic t_report();
		i_wsc_host.got.delete();
		tamper_in <= 1'b1;
		for (n = 0; n < 60 && i_wsc_host.got.size() < 6; n++) @(posedge pclk);
		e = '{8'h55, 8'h55, 8'h02, 8'hff, 8'h00, 8'h0d};
		foreach (e[i]) `CHK(i_wsc_host.got[i], e[i])
		i_wsc_host.got.delete();
		wg_pulse <= 1'b1;
		@(posedge pclk);
		wg_pulse <= 1'b0;
		for (n = 0; n < 14100 && i_wsc_host.got.size() < 20; n++) @(posedge pclk);
		`CHK(i_wsc_host.got.size(), 20)
		e = '{8'h55, 8'h55, 8'h01, 8'h1a, 8'hf2, 8'h62, 8'h70, 8'h40, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00, DEF_TP[7:0], DEF_TB[7:0], 8'h00, 8'h0d};
		foreach (e[i]) `CHK(i_wsc_host.got[i], e[i])
	endtask
	task automatic t_dump();
		i_wsc_host.send('{8'h55, 8'h55, 8'h09, 8'h80, 8'h77, 8'h00, 8'h0d});
		i_wsc_host.got.delete();
		i_wsc_host.send('{8'h55, 8'h55, 8'h0b, 8'h00, 8'h00, 8'h0d});
		for (n = 0; n < 200 && i_wsc_host.got.size() < 133; n++) @(posedge pclk);
		`CHK(i_wsc_host.got.size(), 133)
		e = '{8'h55, 8'h55, 8'h0b, MODE_IN, DEF_TP[15:8], DEF_TP[7:0], DEF_TB[15:8], DEF_TB[7:0]};
		foreach (e[i]) `CHK(i_wsc_host.got[i], e[i])
		`CHK({i_wsc_host.got[131], i_wsc_host.got[132]}, 16'h000d)
	endtask
	task automatic t_reset();
		i_wsc_host.send('{8'h55, 8'h55, 8'h09, 8'h00, MODE_IN, 8'h00, 8'h0d});
		apb(REG_STATUS, 1'b0, 32'h0);
		`CHK(rd[15:8], MODE_AUTO)
		i_wsc_host.send('{8'h55, 8'h55, 8'h0a, 8'h00, 8'h00, 8'h0d});
		for (n = 0; n < 40 && restart_req !== 1'b1; n++) begin
			`CHK(ack_led, 1'b1)
			@(posedge pclk);
		end
		`CHK(n >= 16 && n <= 21, 1'b1)
		repeat (3) @(posedge pclk);
		apb(REG_STATUS, 1'b0, 32'h0);
		`CHK({rd[15:8], rd[1:0], tamper_oe}, {MODE_IN, 2'b01, 1'b0})
		i_wsc_host.send('{8'h55, 8'h55, 8'h02, 8'h00, 8'h00, 8'h0d});
		i_wsc_host.send('{8'h55, 8'h55, 8'h04, 8'hff, 8'h00, 8'h0d});
		`CHK({tamper_out, gpio_oe, gpio_out}, 5'b11110)
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_frame();
		t_pins();
		t_err();
		t_reset();
		t_report();
		t_dump();
		final_report();
	end
	initial begin
		#(40 * 16000);
		fails++;
		final_report();
	end
endmodule

// file: wiegand_cmd.sv
// serial command frame parser and generator of the wiegand converter
`timescale 1ns/100ps
module wiegand_cmd #(
	parameter int RESET_CYCLES = wsc_pkg::SOFT_RESET_CYCLES
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial byte stream in
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid,
	// serial byte stream out
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	// wiegand generator
	output logic      [95:0] wg_bits,
	output logic      [7:0]  wg_count,
	output logic             wg_start,
	output logic      [15:0] wg_pulse_width,
	output logic      [15:0] wg_bit_period,
	// wiegand receiver
	input  wire logic        wg_pulse,
	input  wire logic [95:0] wg_rx_bits,
	input  wire logic [7:0]  wg_rx_count,
	// tamper and general pins
	input  wire logic        tamper_in,
	output logic             tamper_out,
	output logic             tamper_oe,
	input  wire logic [1:0]  gpio_in,
	output logic      [1:0]  gpio_out,
	output logic      [1:0]  gpio_oe,
	// system
	output logic             ack_led,
	output logic             restart_req
);
	import wsc_pkg::*;

	localparam int RCW = $clog2(RESET_CYCLES);
	if (RESET_CYCLES < 2) begin : g_chk
		$error("soft reset delay must be at least two cycles");
	end

	function automatic logic [4:0] cmd_len(input logic [7:0] c);
		case (c)
			CMD_FRAME:                        cmd_len = LEN_FRAME;
			CMD_TAMPER, CMD_GPIO0, CMD_GPIO1: cmd_len = LEN_PIN;
			CMD_CFG_WR:                       cmd_len = LEN_WR;
			CMD_SOFT:                         cmd_len = LEN_SOFT;
			CMD_DUMP:                         cmd_len = LEN_DUMP;
			default:                          cmd_len = 5'd0;
		endcase
	endfunction

	function automatic logic [7:0] level_code(input logic lvl);
		level_code = lvl ? LEVEL_HIGH : LEVEL_LOW;
	endfunction

	// registers
	parse_t      state_r;
	logic [7:0]  cmd_r;
	logic [4:0]  cnt_r;
	logic [119:0] buf_r;
	logic [2:0]  err_r;
	logic [1:0]  ctrl_r;
	logic [31:0] prdata_r;
	logic [7:0]  act_mode_r;
	logic [15:0] act_tp_r;
	logic [15:0] act_tb_r;
	logic [15:0] act_tw_r;
	logic [95:0] wg_bits_r;
	logic [7:0]  wg_count_r;
	logic        wg_start_r;
	logic        tamper_out_r;
	logic [1:0]  gpio_out_r;
	logic [15:0] tmr_r;
	logic        tmr_run_r;
	logic [95:0] tx_bits_r;
	logic [7:0]  tx_nb_r;
	logic        tx_busy_r;
	logic [7:0]  tx_idx_r;
	logic [7:0]  tx_len_r;
	logic [7:0]  tx_cmd_r;
	logic [7:0]  tx_val_r;
	logic [7:0]  tx_data_r;
	tx_kind_t    tx_kind_r;
	logic        frame_pend_r;
	logic        dump_pend_r;
	logic [2:0]  pin_pend_r;
	logic        rst_run_r;
	logic [RCW-1:0] rst_cnt_r;
	logic        restart_r;

	// apb decode
	wire         apb_setup = psel & ~penable;
	wire         apb_wr    = psel & penable & pwrite;
	wire         hit_ctrl  = (paddr == REG_CTRL);
	wire         hit_stat  = (paddr == REG_STATUS);
	wire         hit_err   = (paddr == REG_ERR);
	wire         hit_any   = hit_ctrl | hit_stat | hit_err;
	wire         ctrl_we   = apb_wr & hit_ctrl;
	wire         err_clr   = apb_wr & hit_err;

	// working mode from the settings latched at the last start-up
	wire auto_md = (act_mode_r == MODE_AUTO);
	wire mode_in  = (act_mode_r == MODE_IN) | (auto_md & ctrl_r[CTRL_AUTO_IN]);
	wire mode_out = (act_mode_r == MODE_OUT) | (auto_md & ~ctrl_r[CTRL_AUTO_IN]);

	// parser
	wire       rx_take  = rx_valid & ctrl_r[CTRL_EN] & ~rst_run_r;
	wire [4:0] rx_len   = cmd_len(rx_data);
	wire       is_sync  = (rx_data == SYNC_CHAR);
	wire       is_term  = (rx_data == TERM_CHAR);
	wire       exec     = rx_take & (state_r == P_TERM) & is_term;
	wire       err_sync = rx_take & ((state_r == P_LEAD_MARKER_CHAR) | (state_r == P_SYNC2)) & ~is_sync;
	wire       err_unk  = rx_take & (state_r == P_CMD) & (rx_len == 5'd0);
	wire       err_term = rx_take & (state_r == P_TERM) & ~is_term;
	wire [2:0] err_code = err_sync ? ERR_SYNC : (err_unk ? ERR_UNKNOWN : ERR_TERM);
	wire       err_set  = err_sync | err_unk | err_term;
	wire [7:0] pin_val  = buf_r[7:0];
	wire       val_ok   = (pin_val == LEVEL_HIGH) | (pin_val == LEVEL_LOW);
	wire       do_frame = exec & (cmd_r == CMD_FRAME) & mode_out;
	wire       do_tamp  = exec & (cmd_r == CMD_TAMPER) & mode_out & val_ok;
	wire       do_g0    = exec & (cmd_r == CMD_GPIO0) & mode_in & val_ok;
	wire       do_g1    = exec & (cmd_r == CMD_GPIO1) & mode_in & val_ok;
	wire       cfg_we   = exec & (cmd_r == CMD_CFG_WR) & ~buf_r[15];
	wire       do_soft  = exec & (cmd_r == CMD_SOFT);
	wire       do_dump  = exec & (cmd_r == CMD_DUMP);
	wire       restart  = rst_run_r & (rst_cnt_r == RCW'(RESET_CYCLES - 1));

	// frame timer of the receive direction
	wire       tmr_done = mode_in & ~wg_pulse & tmr_run_r & (tmr_r == TIMER_END);

	// pin change reporting
	wire [2:0] pin_chg;
	wire [2:0] pin_lvl = {gpio_in[1], gpio_in[0], tamper_in};
	wire [2:0] pin_en  = {mode_out, mode_out, mode_in};

	pin_watch #(
		.W (3)
	) u_watch (
		.pclk    (pclk),
		.presetn (presetn),
		.level   (pin_lvl),
		.enable  (pin_en),
		.change  (pin_chg)
	);

	// configuration memory
	wire [7:0]  cfg_rdata;
	wire [7:0]  cfg_mode;
	wire [15:0] cfg_tp;
	wire [15:0] cfg_tb;
	wire [15:0] cfg_tw;
	wire [7:0]  tx_ni   = tx_idx_r + 8'h01;

	cfg_mem #(
		.DEPTH (CFG_DEPTH)
	) u_cfg (
		.pclk      (pclk),
		.presetn   (presetn),
		.we        (cfg_we),
		.waddr     (buf_r[14:8]),
		.wdata     (buf_r[7:0]),
		.raddr     (CFG_AW'(tx_ni - 8'h03)),
		.rdata     (cfg_rdata),
		.mode_byte (cfg_mode),
		.tp_word   (cfg_tp),
		.tb_word   (cfg_tb),
		.tw_word   (cfg_tw)
	);

	// transmitter: next byte of the frame in progress
	wire [6:0] raw_base = 7'(8'd120 - {tx_ni[4:0], 3'b000});
	wire [7:0] raw_byte = tx_bits_r[raw_base +: 8];
	wire [7:0] frm_byte = (tx_ni == 8'd3) ? tx_nb_r :
	                      (tx_ni == 8'd16) ? act_tp_r[7:0] :
	                      (tx_ni == 8'd17) ? act_tb_r[7:0] : raw_byte;
	wire [7:0] body     = (tx_kind_r == K_PIN) ? tx_val_r :
	                      (tx_kind_r == K_FRAME) ? frm_byte : cfg_rdata;
	wire [7:0] next_byte = (tx_ni <= 8'd1) ? SYNC_CHAR :
	                       (tx_ni == 8'd2) ? tx_cmd_r :
	                       (tx_ni == tx_len_r - 8'd2) ? RSV_TX :
	                       (tx_ni == tx_len_r - 8'd1) ? TERM_CHAR : body;
	wire       tx_adv   = tx_busy_r & tx_ready;
	wire       tx_last  = (tx_idx_r == tx_len_r - 8'd1);
	wire       tx_start = ~tx_busy_r & (frame_pend_r | (|pin_pend_r) | dump_pend_r);
	wire       pick_frm = frame_pend_r;
	wire       pick_pin = ~frame_pend_r & (|pin_pend_r);
	wire [2:0] pin_pick = pin_pend_r[0] ? 3'b001 : (pin_pend_r[1] ? 3'b010 : 3'b100);
	wire [7:0] pin_cmd  = pin_pend_r[0] ? CMD_TAMPER : (pin_pend_r[1] ? CMD_GPIO0 : CMD_GPIO1);
	wire       pin_now  = |(pin_pick & pin_lvl);
	wire [2:0] pin_clr  = (tx_start & pick_pin) ? pin_pick : 3'b000;

	// parser state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= P_LEAD_MARKER_CHAR;
			cmd_r   <= 8'h00;
			cnt_r   <= 5'd0;
			buf_r   <= '0;
		end else if (restart) begin
			state_r <= P_LEAD_MARKER_CHAR;
		end else if (rx_take) begin
			case (state_r)
				P_LEAD_MARKER_CHAR: state_r <= is_sync ? P_SYNC2 : P_LEAD_MARKER_CHAR;
				P_SYNC2: state_r <= is_sync ? P_CMD : P_LEAD_MARKER_CHAR;
				P_CMD: begin
					cmd_r   <= rx_data;
					cnt_r   <= rx_len;
					state_r <= (rx_len == 5'd0) ? P_LEAD_MARKER_CHAR : P_DATA;
				end
				P_DATA: begin
					buf_r   <= {buf_r[111:0], rx_data};
					cnt_r   <= cnt_r - 5'd1;
					state_r <= (cnt_r == 5'd1) ? P_RSV : P_DATA;
				end
				P_RSV:   state_r <= P_TERM;
				P_TERM:  state_r <= P_LEAD_MARKER_CHAR;
				default: state_r <= P_LEAD_MARKER_CHAR;
			endcase
		end
	end

	// software registers and error flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= CTRL_RESET;
			err_r    <= ERR_NONE;
			prdata_r <= 32'h0000_0000;
		end else begin
			if (ctrl_we) begin
				ctrl_r <= pwdata[1:0];
			end
			if (err_set) begin
				err_r <= err_code;
			end else if (err_clr) begin
				err_r <= ERR_NONE;
			end
			if (apb_setup) begin
				prdata_r <= hit_ctrl ? {30'h0, ctrl_r} :
				            hit_stat ? {16'h0, act_mode_r, 3'h0, tmr_run_r,
				                        rst_run_r, tx_busy_r, mode_out, mode_in} :
				            hit_err ? {29'h0, err_r} : 32'h0000_0000;
			end
		end
	end

	// active settings, pins and wiegand buffer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_mode_r   <= MODE_AUTO;
			act_tp_r     <= DEF_TP;
			act_tb_r     <= DEF_TB;
			act_tw_r     <= DEF_TW;
			wg_bits_r    <= '0;
			wg_count_r   <= 8'h00;
			wg_start_r   <= 1'b0;
			tamper_out_r <= 1'b0;
			gpio_out_r   <= 2'b00;
		end else begin
			if (restart) begin
				act_mode_r <= cfg_mode;
				act_tp_r   <= cfg_tp;
				act_tb_r   <= cfg_tb;
				act_tw_r   <= cfg_tw;
			end
			wg_start_r <= do_frame;
			if (do_frame) begin
				wg_bits_r  <= buf_r[111:16];
				wg_count_r <= buf_r[119:112];
			end
			if (do_tamp) begin
				tamper_out_r <= (pin_val == LEVEL_HIGH);
			end
			if (do_g0) begin
				gpio_out_r[0] <= (pin_val == LEVEL_HIGH);
			end
			if (do_g1) begin
				gpio_out_r[1] <= (pin_val == LEVEL_HIGH);
			end
		end
	end

	// frame timer, soft reset delay and pending reports
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr_r        <= 16'h0000;
			tmr_run_r    <= 1'b0;
			tx_bits_r    <= '0;
			tx_nb_r      <= 8'h00;
			rst_run_r    <= 1'b0;
			rst_cnt_r    <= '0;
			restart_r    <= 1'b0;
			frame_pend_r <= 1'b0;
			dump_pend_r  <= 1'b0;
			pin_pend_r   <= 3'b000;
		end else begin
			if (!mode_in) begin
				tmr_run_r <= 1'b0;
			end else if (wg_pulse) begin
				tmr_r     <= act_tw_r;
				tmr_run_r <= 1'b1;
			end else if (tmr_done) begin
				tmr_run_r <= 1'b0;
				tx_bits_r <= wg_rx_bits;
				tx_nb_r   <= wg_rx_count;
			end else if (tmr_run_r) begin
				tmr_r <= tmr_r + 16'h0001;
			end
			restart_r <= restart;
			if (restart) begin
				rst_run_r <= 1'b0;
			end else if (do_soft) begin
				rst_run_r <= 1'b1;
				rst_cnt_r <= '0;
			end else if (rst_run_r) begin
				rst_cnt_r <= rst_cnt_r + RCW'(1);
			end
			// a new event wins over the clear of its pending bit
			frame_pend_r <= tmr_done | (frame_pend_r & ~(tx_start & pick_frm));
			dump_pend_r  <= do_dump | (dump_pend_r & ~(tx_start & ~pick_frm & ~pick_pin));
			pin_pend_r   <= pin_chg | (pin_pend_r & ~pin_clr);
		end
	end

	// transmit sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_busy_r <= 1'b0;
			tx_idx_r  <= 8'h00;
			tx_len_r  <= TX_LEN_PIN;
			tx_cmd_r  <= 8'h00;
			tx_val_r  <= 8'h00;
			tx_data_r <= 8'h00;
			tx_kind_r <= K_PIN;
		end else if (tx_start) begin
			tx_busy_r <= 1'b1;
			tx_idx_r  <= 8'h00;
			tx_data_r <= SYNC_CHAR;
			tx_kind_r <= pick_frm ? K_FRAME : (pick_pin ? K_PIN : K_DUMP);
			tx_len_r  <= pick_frm ? TX_LEN_FRAME : (pick_pin ? TX_LEN_PIN : TX_LEN_DUMP);
			tx_cmd_r  <= pick_frm ? CMD_FRAME : (pick_pin ? pin_cmd : CMD_DUMP);
			tx_val_r  <= level_code(pin_now);
		end else if (tx_adv) begin
			tx_busy_r <= ~tx_last;
			tx_idx_r  <= tx_ni;
			tx_data_r <= next_byte;
		end
	end

	// outputs
	assign prdata         = prdata_r;
	assign pready         = 1'b1;
	assign pslverr        = psel & penable & ~hit_any;
	assign tx_data        = tx_data_r;
	assign tx_valid       = tx_busy_r;
	assign wg_bits        = wg_bits_r;
	assign wg_count       = wg_count_r;
	assign wg_start       = wg_start_r;
	assign wg_pulse_width = act_tp_r;
	assign wg_bit_period  = act_tb_r;
	assign tamper_out     = tamper_out_r;
	assign tamper_oe      = mode_out;
	assign gpio_out       = gpio_out_r;
	assign gpio_oe        = {mode_in, mode_in};
	assign ack_led        = rst_run_r;
	assign restart_req    = restart_r;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_sync_error: assert property (rx_take && state_r == P_LEAD_MARKER_CHAR && !is_sync
		|=> err_r == ERR_SYNC) else $error("bad sync char not flagged");
	a_term_check: assert property (rx_take && state_r == P_TERM && !is_term
		|=> err_r == ERR_TERM && !wg_start_r) else $error("bad terminator acted on");
	a_frame_copy: assert property (do_frame |=> wg_start_r
		&& wg_bits_r == $past(buf_r[111:16])) else $error("frame bits not copied");
	a_tamper_discard: assert property (!mode_out |=> $stable(tamper_out_r))
		else $error("tamper changed outside output mode");
	a_gpio_discard: assert property (!mode_in |=> $stable(gpio_out_r))
		else $error("gpio changed outside input mode");
	a_cfg_guard: assert property (exec && cmd_r == CMD_CFG_WR && buf_r[15] |-> !cfg_we)
		else $error("write above 127 accepted");
	a_settings_hold: assert property (!restart |=> $stable(act_mode_r)
		&& $stable(act_tp_r) && $stable(act_tb_r)) else $error("settings moved");
	a_reset_led: assert property (do_soft && !rst_run_r
		|=> ack_led [*8] ##0 !restart_req) else $error("ack led not held");
	a_timer_end: assert property (tmr_done |=> frame_pend_r && !tmr_run_r)
		else $error("timer end missed");
	a_tx_first: assert property (tx_start |=> tx_valid && tx_data == SYNC_CHAR ##0
		tx_idx_r == 8'h00) else $error("frame not opened by sync");
	a_tx_last: assert property (tx_busy_r && tx_last |-> tx_data == TERM_CHAR)
		else $error("frame not closed by terminator");
	a_pin_report: assert property (pin_chg[0] |=> pin_pend_r[0] || tx_busy_r)
		else $error("tamper change lost");
endmodule

// file: wsc_host.sv
// host-side serial partner: sends command frames and collects reply bytes
`timescale 1ns/100ps
module wsc_host (
	// clock and pace
	input  wire logic       pclk,
	input  wire logic       slow,
	// byte stream towards the block
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	// byte stream from the block
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic [7:0] got[$];
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
	end
	// whole frame back to back, one byte per cycle, then an idle cycle
	task automatic send(input logic [7:0] f[$]);
		foreach (f[i]) begin
			rx_data <= f[i];
			rx_valid <= 1'b1;
			@(posedge pclk);
		end
		rx_data <= ~f[f.size()-1];
		rx_valid <= 1'b0;
		@(posedge pclk);
	endtask
	// slow pace stalls every other cycle
	always @(posedge pclk) begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end
endmodule

// file: wsc_pkg.sv
// shared constants, types and helpers of the serial command handler
package wsc_pkg;
	// framing characters
	localparam logic [7:0] SYNC_CHAR  = 8'h55;
	localparam logic [7:0] TERM_CHAR  = 8'h0d;
	localparam logic [7:0] RSV_TX     = 8'h00;
	localparam logic [7:0] LEVEL_LOW  = 8'h00;
	localparam logic [7:0] LEVEL_HIGH = 8'hff;
	// command codes
	localparam logic [7:0] CMD_FRAME  = 8'h01;
	localparam logic [7:0] CMD_TAMPER = 8'h02;
	localparam logic [7:0] CMD_GPIO0  = 8'h03;
	localparam logic [7:0] CMD_GPIO1  = 8'h04;
	localparam logic [7:0] CMD_CFG_WR = 8'h09;
	localparam logic [7:0] CMD_SOFT   = 8'h0a;
	localparam logic [7:0] CMD_DUMP   = 8'h0b;
	// data bytes between command code and reserved char
	localparam logic [4:0] LEN_FRAME  = 5'd15;
	localparam logic [4:0] LEN_PIN    = 5'd1;
	localparam logic [4:0] LEN_WR     = 5'd2;
	localparam logic [4:0] LEN_SOFT   = 5'd1;
	localparam logic [4:0] LEN_DUMP   = 5'd1;
	// transmitted frame lengths in bytes
	localparam logic [7:0] TX_LEN_PIN   = 8'd6;
	localparam logic [7:0] TX_LEN_FRAME = 8'd20;
	localparam logic [7:0] TX_LEN_DUMP  = 8'd133;
	localparam int         RAW_BITS     = 96;
	// working modes
	localparam logic [7:0] MODE_AUTO = 8'ha5;
	localparam logic [7:0] MODE_IN   = 8'h0f;
	localparam logic [7:0] MODE_OUT  = 8'hf0;
	// configuration memory
	localparam int         CFG_DEPTH = 128;
	localparam int         CFG_AW    = 7;
	localparam logic [6:0] ADDR_MODE = 7'h00;
	localparam logic [6:0] ADDR_TP   = 7'h01;
	localparam logic [6:0] ADDR_TB   = 7'h03;
	localparam logic [6:0] ADDR_TW   = 7'h05;
	localparam logic [15:0] DEF_TP   = 16'h000d;
	localparam logic [15:0] DEF_TB   = 16'h1ccc;
	localparam logic [15:0] DEF_TW   = 16'hc9ff;
	localparam logic [15:0] TIMER_END = 16'hffff;
	// error codes
	localparam logic [2:0] ERR_NONE    = 3'h0;
	localparam logic [2:0] ERR_SYNC    = 3'h1;
	localparam logic [2:0] ERR_UNKNOWN = 3'h2;
	localparam logic [2:0] ERR_TERM    = 3'h3;
	// register map
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_ERR    = 12'h008;
	localparam int          CTRL_EN    = 0;
	localparam int          CTRL_AUTO_IN = 1;
	localparam logic [1:0]  CTRL_RESET = 2'h1;
	// soft reset delay
	localparam int SOFT_RESET_MS     = 2000;
	localparam int CLK_PERIOD_NS     = 40;
	localparam int SOFT_RESET_CYCLES = SOFT_RESET_MS * (1000000 / CLK_PERIOD_NS);

	typedef enum logic [2:0] {P_LEAD_MARKER_CHAR, P_SYNC2, P_CMD, P_DATA, P_RSV, P_TERM} parse_t;
	typedef enum logic [1:0] {K_PIN, K_FRAME, K_DUMP} tx_kind_t;

	function automatic logic [7:0] cfg_default(input int unsigned a);
		case (a)
			0:       cfg_default = MODE_AUTO;
			1:       cfg_default = DEF_TP[15:8];
			2:       cfg_default = DEF_TP[7:0];
			3:       cfg_default = DEF_TB[15:8];
			4:       cfg_default = DEF_TB[7:0];
			5:       cfg_default = DEF_TW[15:8];
			6:       cfg_default = DEF_TW[7:0];
			7, 8:    cfg_default = 8'h01;
			9:       cfg_default = 8'h04;
			10:      cfg_default = 8'h01;
			93:      cfg_default = 8'h10;
			default: cfg_default = 8'h00;
		endcase
	endfunction
endpackage
